// >>> design/dics_top.sv
// ddr3 init command sequencer: control bits, command issue, freq-change gate
// Operation
// - zq sets bit 10, clears flag when sent
// - mr command driven then its flag cleared
// - init mode selects all ranks for mr and zq, else one; control words use the rank mask
// - control word index and data bit placement
// - control word sent to masked ranks, cleared
// - fence training enable held then cleared
// - pll change only from proper triggers
// - init mode falling ends software initialization
`timescale 1ns/1ps
`include "dics_cfg.svh"
module dics_top (
	input wire logic clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic mem_clk,
	input wire logic mem_rst,
	input wire logic init_mode_enable,
	input wire logic release_mem_reset,
	input wire logic drive_clock_enable,
	input wire logic addr_swap_flag,
	input wire logic [`DICS_BANK_W-1:0] mr_bank_select,
	input wire logic [2:0] mr_rank_select,
	input wire logic [`DICS_ADDR_W-1:0] mr_address_value,
	input wire logic [`DICS_CS_W-1:0] ctrl_word_rank_mask,
	input wire logic set_mr_cmd,
	input wire logic set_zq_cmd,
	input wire logic set_ctrl_word,
	input wire logic fence_training_enable,
	input wire logic init_trigger,
	input wire logic exit_self_refresh,
	input wire logic freq_valid,
	input wire logic [`DICS_FREQ_W-1:0] target_frequency,
	output logic issue_mr_cmd,
	output logic issue_zq_cmd,
	output logic issue_ctrl_word,
	output logic init_done,
	output logic fence_active,
	output logic pll_change_req,
	output logic [`DICS_FREQ_W-1:0] pll_frequency,
	output logic mem_reset_n,
	output logic mem_cke,
	output logic [`DICS_CS_W-1:0] mem_cs_n,
	output logic mem_ras_n,
	output logic mem_cas_n,
	output logic mem_we_n,
	output logic [`DICS_BANK_W-1:0] mem_ba,
	output logic [`DICS_ADDR_W-1:0] mem_a
);
	import dics_pkg::*;
	dics_link_if lk ();
	logic req_t;
	logic ack_s1;
	logic ack_s2;
	logic ack_seen;
	logic busy;
	logic init_prev;
	logic initialized;
	dics_cmd_type cmd_r;
	logic [`DICS_BANK_W-1:0] bank_r;
	logic [`DICS_ADDR_W-1:0] addr_r;
	logic [`DICS_CS_W-1:0] cs_r;
	logic next_mr;
	logic next_zq;
	logic next_cw;

	function automatic logic [`DICS_CS_W-1:0] rank_onehot(input logic [2:0] idx);
		rank_onehot = `DICS_CS_W'(1) << idx;
	endfunction : rank_onehot

	// mirrored odd ranks: swap address and bank pairs per ddr3 mirroring
	function automatic logic [`DICS_ADDR_W-1:0] swap_addr(input logic [`DICS_ADDR_W-1:0] a);
		logic [`DICS_ADDR_W-1:0] r;
		r = a;
		r[3] = a[4];
		r[4] = a[3];
		r[5] = a[6];
		r[6] = a[5];
		r[7] = a[8];
		r[8] = a[7];
		swap_addr = r;
	endfunction : swap_addr

	function automatic logic [`DICS_BANK_W-1:0] swap_bank(input logic [`DICS_BANK_W-1:0] b);
		swap_bank = {b[2], b[0], b[1]};
	endfunction : swap_bank

	assign lk.req_toggle = req_t;
	assign lk.cmd = cmd_r;
	assign lk.bank = bank_r;
	assign lk.addr = addr_r;
	assign lk.cs_sel = cs_r;
	assign busy = req_t != ack_seen;

	always_ff @(posedge clk) begin
		if (rst) begin
			ack_s1 <= 1'b0;
			ack_s2 <= 1'b0;
		end else if (clk_en) begin
			ack_s1 <= lk.ack_toggle;
			ack_s2 <= ack_s1;
		end
	end

	// command launch: one at a time, fields frozen while busy
	always_ff @(posedge clk) begin
		if (rst) begin
			req_t <= 1'b0;
			ack_seen <= 1'b0;
			cmd_r <= DICS_CMD_MR;
			bank_r <= '0;
			addr_r <= '0;
			cs_r <= '0;
		end else if (clk_en) begin
			ack_seen <= ack_s2;
			if (!busy && ack_seen == ack_s2) begin
				if (issue_mr_cmd) begin
					cmd_r <= DICS_CMD_MR;
					bank_r <= mr_bank_select;
					addr_r <= mr_address_value;
					cs_r <= init_mode_enable ? '1 : rank_onehot(mr_rank_select);
					if (addr_swap_flag && !init_mode_enable && mr_rank_select[0]) begin
						bank_r <= swap_bank(mr_bank_select);
						addr_r <= swap_addr(mr_address_value);
					end
					req_t <= ~req_t;
				end else if (issue_zq_cmd) begin
					cmd_r <= DICS_CMD_ZQ;
					bank_r <= '0;
					addr_r <= `DICS_ADDR_W'(1) << `DICS_ZQ_BIT;
					cs_r <= init_mode_enable ? '1 : rank_onehot(mr_rank_select);
					req_t <= ~req_t;
				end else if (issue_ctrl_word) begin
					cmd_r <= DICS_CMD_CW;
					// index on ba2,a2,a1,a0; data on ba1,ba0,a4,a3
					bank_r <= mr_bank_select;
					addr_r <= {{(`DICS_ADDR_W-5){1'b0}}, mr_address_value[4:0]};
					cs_r <= ctrl_word_rank_mask;
					req_t <= ~req_t;
				end
			end
		end
	end

	// flags: set wins over completion; cleared when link reports done
	always_comb begin
		next_mr = issue_mr_cmd;
		next_zq = issue_zq_cmd;
		next_cw = issue_ctrl_word;
		if (busy && ack_s2 != ack_seen) begin
			case (cmd_r)
				DICS_CMD_MR: next_mr = 1'b0;
				DICS_CMD_ZQ: next_zq = 1'b0;
				DICS_CMD_CW: next_cw = 1'b0;
				default: next_mr = issue_mr_cmd;
			endcase
		end
		if (set_mr_cmd) begin
			next_mr = 1'b1;
		end
		if (set_zq_cmd) begin
			next_zq = 1'b1;
		end
		if (set_ctrl_word) begin
			next_cw = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			issue_mr_cmd <= 1'b0;
			issue_zq_cmd <= 1'b0;
			issue_ctrl_word <= 1'b0;
		end else if (clk_en) begin
			issue_mr_cmd <= next_mr;
			issue_zq_cmd <= next_zq;
			issue_ctrl_word <= next_cw;
		end
	end

	// init completion and frequency-change gating
	always_ff @(posedge clk) begin
		if (rst) begin
			init_prev <= 1'b0;
			init_done <= 1'b0;
			initialized <= 1'b0;
			pll_change_req <= 1'b0;
			pll_frequency <= `DICS_FREQ_RST;
		end else if (clk_en) begin
			init_prev <= init_mode_enable;
			if (init_prev && !init_mode_enable) begin
				init_done <= 1'b1;
			end
			pll_change_req <= 1'b0;
			if (init_mode_enable || init_trigger || exit_self_refresh) begin
				initialized <= 1'b1;
			end
			// bare freq_valid on an untouched channel leaves the pll alone
			if (init_mode_enable && !init_prev || init_trigger || exit_self_refresh
				|| freq_valid && initialized) begin
				pll_change_req <= 1'b1;
				pll_frequency <= target_frequency;
			end
		end
	end

	// pins that follow the firmware control bits
	always_ff @(posedge clk) begin
		if (rst) begin
			mem_reset_n <= 1'b0;
			mem_cke <= 1'b0;
			fence_active <= 1'b0;
		end else if (clk_en) begin
			mem_reset_n <= release_mem_reset;
			mem_cke <= drive_clock_enable;
			fence_active <= fence_training_enable;
		end
	end

	dics_link u_link (
		.mem_clk(mem_clk),
		.mem_rst(mem_rst),
		.lk(lk.link),
		.mem_cs_n(mem_cs_n),
		.mem_ras_n(mem_ras_n),
		.mem_cas_n(mem_cas_n),
		.mem_we_n(mem_we_n),
		.mem_ba(mem_ba),
		.mem_a(mem_a)
	);
endmodule : dics_top

// >>> design/dics_cfg.svh
// constants for the ddr3 init command sequencer
`ifndef DICS_CFG_SVH
`define DICS_CFG_SVH
`define DICS_ADDR_W 16
`define DICS_BANK_W 3
`define DICS_CS_W 8
`define DICS_ZQ_BIT 10
`define DICS_DLL_RST_BIT 8
`define DICS_CMD_GAP_NS 40
`define DICS_CLK_NS 10
`define DICS_CMD_GAP_CYC ((`DICS_CMD_GAP_NS + `DICS_CLK_NS - 1) / `DICS_CLK_NS)
`define DICS_ZQ_WAIT_MCLK 512
`define DICS_CW_WORDS 16
`define DICS_FREQ_W 3
`define DICS_FREQ_RST 3'h0
`endif

// >>> design/dics_pkg.sv
// types for the ddr3 init command sequencer
`include "dics_cfg.svh"
package dics_pkg;
	typedef enum logic [1:0] {
		DICS_CMD_MR,
		DICS_CMD_ZQ,
		DICS_CMD_CW
	} dics_cmd_type;
	typedef enum logic [2:0] {
		DICS_ST_IDLE,
		DICS_ST_DRIVE,
		DICS_ST_WAIT,
		DICS_ST_DONE
	} dics_state_type;
endpackage : dics_pkg

// >>> design/dics_link_if.sv
// command hand-off between control domain and memory-clock link logic
`timescale 1ns/1ps
`include "dics_cfg.svh"
interface dics_link_if;
	import dics_pkg::*;
	logic req_toggle;
	logic ack_toggle;
	dics_cmd_type cmd;
	logic [`DICS_BANK_W-1:0] bank;
	logic [`DICS_ADDR_W-1:0] addr;
	logic [`DICS_CS_W-1:0] cs_sel;
	modport ctrl (output req_toggle, output cmd, output bank, output addr, output cs_sel,
		input ack_toggle);
	modport link (input req_toggle, input cmd, input bank, input addr, input cs_sel,
		output ack_toggle);
endinterface : dics_link_if

// >>> design/dics_link.sv
// memory-clock side: drives one command onto the dram bus per request
`timescale 1ns/1ps
`include "dics_cfg.svh"
module dics_link #(
	parameter int GAP_CYC = `DICS_CMD_GAP_CYC,
	parameter int ZQ_WAIT = `DICS_ZQ_WAIT_MCLK
) (
	input wire logic mem_clk,
	input wire logic mem_rst,
	dics_link_if.link lk,
	output logic [`DICS_CS_W-1:0] mem_cs_n,
	output logic mem_ras_n,
	output logic mem_cas_n,
	output logic mem_we_n,
	output logic [`DICS_BANK_W-1:0] mem_ba,
	output logic [`DICS_ADDR_W-1:0] mem_a
);
	import dics_pkg::*;
	logic req_s1;
	logic req_s2;
	logic req_seen;
	logic ack;
	logic [9:0] cnt;
	dics_state_type state;
	assign lk.ack_toggle = ack;
	always_ff @(posedge mem_clk) begin
		if (mem_rst) begin
			req_s1 <= 1'b0;
			req_s2 <= 1'b0;
		end else begin
			req_s1 <= lk.req_toggle;
			req_s2 <= req_s1;
		end
	end
	// request fields change on the same edge as the toggle and stay frozen until the ack, so sampling them after the two-flop sync is safe
	always_ff @(posedge mem_clk) begin
		if (mem_rst) begin
			state <= DICS_ST_IDLE;
			req_seen <= 1'b0;
			ack <= 1'b0;
			cnt <= 10'h000;
			mem_cs_n <= '1;
			mem_ras_n <= 1'b1;
			mem_cas_n <= 1'b1;
			mem_we_n <= 1'b1;
			mem_ba <= '0;
			mem_a <= '0;
		end else begin
			case (state)
				DICS_ST_IDLE: begin
					if (req_s2 != req_seen) begin
						req_seen <= req_s2;
						state <= DICS_ST_DRIVE;
					end
				end
				DICS_ST_DRIVE: begin
					mem_cs_n <= ~lk.cs_sel;
					mem_ba <= lk.bank;
					mem_a <= lk.addr;
					if (lk.cmd == DICS_CMD_ZQ) begin
						mem_ras_n <= 1'b1;
						mem_cas_n <= 1'b1;
						mem_we_n <= 1'b0;
						cnt <= 10'(ZQ_WAIT - 1);
					end else begin
						mem_ras_n <= 1'b0;
						mem_cas_n <= 1'b0;
						mem_we_n <= 1'b0;
						cnt <= 10'(GAP_CYC - 1);
					end
					state <= DICS_ST_WAIT;
				end
				DICS_ST_WAIT: begin
					mem_cs_n <= '1;
					mem_ras_n <= 1'b1;
					mem_cas_n <= 1'b1;
					mem_we_n <= 1'b1;
					if (cnt == 10'h000) begin
						state <= DICS_ST_DONE;
					end else begin
						cnt <= cnt - 10'h001;
					end
				end
				DICS_ST_DONE: begin
					ack <= ~ack;
					state <= DICS_ST_IDLE;
				end
				default: state <= DICS_ST_IDLE;
			endcase
		end
	end
endmodule : dics_link

// >>> tb/dics_monitor.sv
// pin-level assertions for the init command sequencer
`timescale 1ns/1ps
`include "dics_cfg.svh"
module dics_monitor (
	input wire logic clk,
	input wire logic rst,
	input wire logic mem_clk,
	input wire logic mem_rst,
	input wire logic init_mode_enable,
	input wire logic set_mr_cmd,
	input wire logic set_ctrl_word,
	input wire logic issue_mr_cmd,
	input wire logic issue_zq_cmd,
	input wire logic issue_ctrl_word,
	input wire logic init_done,
	input wire logic pll_change_req,
	input wire logic [`DICS_CS_W-1:0] mem_cs_n,
	input wire logic mem_ras_n,
	input wire logic mem_cas_n,
	input wire logic mem_we_n,
	input wire logic [`DICS_ADDR_W-1:0] mem_a
);
	wire logic cmd_on = mem_cs_n != '1;
	AST_MR_SET: assert property (@(posedge clk) disable iff (rst)
		set_mr_cmd |=> issue_mr_cmd) else $error("mr flag not raised");
	AST_CW_SET: assert property (@(posedge clk) disable iff (rst)
		set_ctrl_word |=> issue_ctrl_word) else $error("cw flag not raised");
	AST_ZQ_HOLD: assert property (@(posedge clk) disable iff (rst)
		$rose(issue_zq_cmd) |=> issue_zq_cmd[*8]) else $error("zq flag dropped early");
	AST_INIT_END: assert property (@(posedge clk) disable iff (rst)
		$fell(init_mode_enable) |-> ##[1:2] init_done) else $error("init end missed");
	AST_PLL_INIT: assert property (@(posedge clk) disable iff (rst)
		$rose(init_mode_enable) |-> ##[1:3] pll_change_req) else $error("no pll change");
	AST_ALL_RANKS: assert property (@(posedge mem_clk) disable iff (mem_rst)
		!mem_ras_n && !mem_cas_n && !mem_we_n && init_mode_enable && !issue_ctrl_word
		|-> mem_cs_n == '0) else $error("init command not on all ranks");
	AST_CMD_PULSE: assert property (@(posedge mem_clk) disable iff (mem_rst)
		cmd_on |=> !cmd_on) else $error("command longer than one cycle");
	AST_ZQ_A10: assert property (@(posedge mem_clk) disable iff (mem_rst)
		cmd_on && mem_ras_n && mem_cas_n && !mem_we_n |-> mem_a[10])
		else $error("zq without address bit 10");
endmodule : dics_monitor

// >>> tb/dics_dimm_model.sv
// dimm-side watcher: latches each command seen on the pins
`timescale 1ns/1ps
module dics_dimm_model (
	input wire logic mem_clk,
	input wire logic [7:0] cs_n,
	input wire logic [2:0] cmd,
	input wire logic [2:0] ba,
	input wire logic [15:0] a,
	output logic [29:0] last,
	output int count
);
	initial count = 0;
	initial last = '0;
	// dimms only listen here, so nothing is driven back
	always @(posedge mem_clk) begin
		if (cs_n != 8'hff) begin
			last <= {cs_n, cmd, ba, a};
			count <= count + 1;
		end
	end
endmodule : dics_dimm_model

// >>> tb/test_dics_top.sv
// self-checking bench for the init command sequencer
`timescale 1ns/1ps
`include "dics_cfg.svh"
module test_dics_top;
	logic clk = 1'h0, rst = 1'h1, clk_en = 1'h1, mem_clk = 1'h0, mem_rst = 1'h1;
	logic init_mode_enable = 1'h0, release_mem_reset = 1'h0, drive_clock_enable = 1'h0;
	logic addr_swap_flag = 1'h0, fence_training_enable = 1'h0;
	logic [2:0] mr_bank_select = '0, mr_rank_select = '0, target_frequency = 3'h5;
	logic [15:0] mr_address_value = '0;
	logic [7:0] ctrl_word_rank_mask = 8'h03;
	logic set_mr_cmd = 1'h0, set_zq_cmd = 1'h0, set_ctrl_word = 1'h0;
	logic init_trigger = 1'h0, exit_self_refresh = 1'h0, freq_valid = 1'h0;
	logic issue_mr_cmd, issue_zq_cmd, issue_ctrl_word, init_done, fence_active;
	logic pll_change_req, mem_reset_n, mem_cke, mem_ras_n, mem_cas_n, mem_we_n;
	logic [2:0] pll_frequency, mem_ba;
	logic [7:0] mem_cs_n;
	logic [15:0] mem_a;
	logic [29:0] last;
	logic [2:0] mrb [4] = '{3'h2, 3'h3, 3'h1, 3'h0};
	// mr2, mr3, mr1, mr0 with dll reset; fields placed per register layout
	logic [15:0] mra [4] = '{16'h0628, 16'h0007, 16'h1a66, 16'h150d};
	int count, err_total = 0, check_count = 0, cyc = 0, pll_seen = 0;
	initial forever #5 clk = ~clk;
	initial begin
		#3;
		forever #32 mem_clk = ~mem_clk;
	end
	dics_top u_dics_top (.*);
	dics_dimm_model u_dics_dimm_model (.mem_clk(mem_clk), .cs_n(mem_cs_n),
		.cmd({mem_ras_n, mem_cas_n, mem_we_n}), .ba(mem_ba), .a(mem_a), .last(last),
		.count(count));
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : complete_run
	// limit is well above the two long zq waits plus the rest
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (pll_change_req === 1'h1)
			pll_seen <= pll_seen + 1;
		if (cyc == 40000) begin
			err_total++;
			complete_run();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (e !== g) begin
			err_total++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task automatic trig(input logic [2:0] t);
		{init_trigger, exit_self_refresh, freq_valid} <= t;
		tick(1);
		{init_trigger, exit_self_refresh, freq_valid} <= 3'h0;
		tick(4);
	endtask : trig
	task automatic send(input logic [2:0] k, input logic [2:0] b, input logic [15:0] a,
		input logic [29:0] e);
		int n;
		int c;
		c = count;
		mr_bank_select <= b;
		mr_address_value <= a;
		{set_mr_cmd, set_zq_cmd, set_ctrl_word} <= k;
		tick(1);
		{set_mr_cmd, set_zq_cmd, set_ctrl_word} <= 3'h0;
		tick(2);
		n = 0;
		while ({issue_mr_cmd, issue_zq_cmd, issue_ctrl_word} !== 3'h0 && n < 9000) begin
			tick(1);
			n++;
		end
		chk("bus", e, last);
		chk("count", c + 1, count);
	endtask : send
	initial begin
		tick(5);
		rst <= 1'h0;
		tick(20);
		mem_rst <= 1'h0;
		tick(2);
		chk("flags", 3'h0, {issue_mr_cmd, issue_zq_cmd, issue_ctrl_word});
		trig(3'h1);
		chk("early pll", 0, pll_seen);
		init_mode_enable <= 1'h1;
		tick(5);
		chk("pll", 1, pll_seen);
		chk("freq", 3'h5, pll_frequency);
		release_mem_reset <= 1'h1;
		drive_clock_enable <= 1'h1;
		fence_training_enable <= 1'h1;
		tick(3);
		chk("pins", 3'h7, {mem_reset_n, mem_cke, fence_active});
		$display("test power-up done");
		send(3'h1, 3'h7, 16'h0001, {8'hfc, 3'h0, 3'h7, 16'h0001});
		send(3'h1, 3'h1, 16'h0002, {8'hfc, 3'h0, 3'h1, 16'h0002});
		for (int i = 0; i < 4; i++)
			send(3'h4, mrb[i], mra[i], {8'h00, 3'h0, mrb[i], mra[i]});
		repeat (2) send(3'h2, 3'h0, 16'h0400, {8'h00, 3'h6, 3'h0, 16'h0400});
		init_mode_enable <= 1'h0;
		tick(3);
		chk("init done", 1'h1, init_done);
		$display("test init sequence done");
		mr_rank_select <= 3'h2;
		send(3'h4, 3'h1, 16'h0006, {8'hfb, 3'h0, 3'h1, 16'h0006});
		// mirrored odd rank: a3/a4 and ba0/ba1 trade places
		addr_swap_flag <= 1'h1;
		mr_rank_select <= 3'h1;
		send(3'h4, 3'h1, 16'h0008, {8'hfd, 3'h0, 3'h2, 16'h0010});
		addr_swap_flag <= 1'h0;
		trig(3'h1);
		trig(3'h4);
		trig(3'h2);
		chk("pll", 4, pll_seen);
		fence_training_enable <= 1'h0;
		tick(2);
		chk("fence", 1'h0, fence_active);
		$display("test post-init done");
		complete_run();
	end
endmodule : test_dics_top
bind dics_top dics_monitor u_dics_monitor (.*);
